// File: design/pxcd_cfg.svh
// Constants for the port expander with change detection
`ifndef PXCD_CFG_SVH
`define PXCD_CFG_SVH
// Fixed upper slave address bits
`define PXCD_ADDR_FIXED 3'h6
// Four-level address-select codes: bus clock, bus data, ground, supply
`define PXCD_SEL_SCL 2'h0
`define PXCD_SEL_SDA 2'h1
`define PXCD_SEL_GND 2'h2
`define PXCD_SEL_VCC 2'h3
// Port output register before the straps are caught: all released
`define PXCD_OUT_RST 8'hff
// Bits per byte before the acknowledge slot
`define PXCD_BYTE_BITS 4'h8
// Cycles after reset release before straps are taken (synchroniser depth)
`define PXCD_STRAP_WAIT 2'h2
`endif

// File: design/pxcd_pkg.sv
// Types shared by the port expander design
package pxcd_pkg;
  // Serial link lines as seen at the pins
  typedef struct packed {
    logic scl;
    logic sda;
  } pxcd_link_s;
  // Open-drain data line drive
  typedef struct packed {
    logic out;
    logic oe;
  } pxcd_pad_s;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WR,
    ST_WACK,
    ST_RD,
    ST_RACK
  } pxcd_state_e;
endpackage

// File: design/pxcd_top.sv
// Serial-slave eight-bit open-drain port expander with change detection
`timescale 1ns/1ns
`default_nettype none
`include "pxcd_cfg.svh"
module pxcd_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire pxcd_pkg::pxcd_link_s link_in,
  output pxcd_pkg::pxcd_pad_s sda_pad,
  input wire logic bus_reset_n,
  input wire logic [1:0] addr_select_high,
  input wire logic [1:0] addr_select_low,
  input wire logic [7:0] io_port_pins_in,
  output logic [7:0] io_port_pins_out,
  output logic [7:0] io_port_pins_oe,
  output logic alert_n
);
  import pxcd_pkg::*;

  // Nibble default from a select strap: only a ground tie gives low
  function automatic logic [3:0] nib_dflt(input logic [1:0] sel);
    nib_dflt = (sel == `PXCD_SEL_GND) ? 4'h0 : 4'hf;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [14:0] sync1_q;
  logic [14:0] sync2_q;
  logic scl_s, sda_s, brst_n_s;
  logic [1:0] ah_s, al_s;
  logic [7:0] in_s;

  // Every input but sys_clk and rstn, link clock included, passes two flops before use
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 15'h7fff;
      sync2_q <= 15'h7fff;
    end else begin
      sync1_q <= {link_in.scl, link_in.sda, bus_reset_n, addr_select_high,
                  addr_select_low, io_port_pins_in};
      sync2_q <= sync1_q;
    end
  end
  assign {scl_s, sda_s, brst_n_s, ah_s, al_s, in_s} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Line edge and condition detection
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // Data moving while clock stays high marks start or stop
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture: power-up defaults and per-transmission address
  logic [1:0] init_q;
  logic [1:0] ah_q, al_q;
  logic strap_load;
  logic [6:0] own_addr;

  assign strap_load = (init_q == `PXCD_STRAP_WAIT);

  // Straps are caught after reset release, once synchronised
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      init_q <= 2'h0;
      ah_q <= `PXCD_SEL_VCC;
      al_q <= `PXCD_SEL_VCC;
    end else begin
      if (init_q != 2'h3)
        init_q <= init_q + 2'h1;
      if (strap_load || start_det) begin
        ah_q <= ah_s;
        al_q <= al_s;
      end
    end
  end
  assign own_addr = {`PXCD_ADDR_FIXED, ah_q, al_q};

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine
  pxcd_state_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic rw_q, flag_next_q, rd_busy_q;
  logic addr_match, byte_end, ack_evt, wr_apply, rd_ack;

  assign addr_match = (sh_q[7:1] == own_addr);
  assign byte_end = scl_fall && (cnt_q == `PXCD_BYTE_BITS);
  // Own address acknowledged: clock rises in the acknowledge slot
  assign ack_evt = (st_q == ST_AACK) && scl_rise;
  assign wr_apply = (st_q == ST_WACK) && scl_rise;
  // Master acknowledge ahead of a port byte triggers a resample
  assign rd_ack = (st_q == ST_RACK) && scl_rise && !sda_s && !flag_next_q;

  // Byte framing; reset pin forces the idle stop state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
    end else if (!brst_n_s || stop_det) begin
      st_q <= ST_IDLE;
    end else if (start_det) begin
      st_q <= ST_ADDR;
      cnt_q <= 4'h0;
    end else begin
      if (scl_rise && (st_q == ST_ADDR || st_q == ST_WR || st_q == ST_RD)) begin
        sh_q <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end
      case (st_q)
        ST_ADDR: if (byte_end) begin
          rw_q <= sh_q[0];
          st_q <= addr_match ? ST_AACK : ST_IDLE;
        end
        ST_AACK: if (scl_fall) begin
          cnt_q <= 4'h0;
          st_q <= rw_q ? ST_RD : ST_WR;
        end
        ST_WR: if (byte_end) begin
          st_q <= ST_WACK;
        end
        ST_WACK: if (scl_fall) begin
          cnt_q <= 4'h0;
          st_q <= ST_WR;
        end
        ST_RD: if (byte_end) begin
          st_q <= ST_RACK;
        end
        ST_RACK: if (scl_rise) begin
          // Master not acknowledging ends the read until the stop
          st_q <= sda_s ? ST_IDLE : ST_RACK;
        end else if (scl_fall) begin
          cnt_q <= 4'h0;
          st_q <= ST_RD;
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // Transmit byte: port snapshot and reported flags alternate
  logic [7:0] snap_q, flags_q, rpt_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 8'h00;
      flag_next_q <= 1'b0;
    end else if ((st_q == ST_AACK || st_q == ST_RACK) && scl_fall && rw_q) begin
      tx_q <= flag_next_q ? rpt_q : snap_q;
      flag_next_q <= ~flag_next_q;
    end else if (st_q == ST_RD && scl_fall && cnt_q != 4'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end else if (st_q == ST_ADDR) begin
      flag_next_q <= 1'b0;
    end
  end

  // Data line drive: acknowledge slots and zero bits of a read byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sda_pad <= '0;
    end else begin
      sda_pad.out <= 1'b0;
      if (!brst_n_s || stop_det || start_det)
        sda_pad.oe <= 1'b0;
      else if ((st_q == ST_ADDR && byte_end && addr_match) || (st_q == ST_WR && byte_end))
        sda_pad.oe <= 1'b1;
      else if ((st_q == ST_AACK || st_q == ST_RACK) && scl_fall && rw_q)
        sda_pad.oe <= ~(flag_next_q ? rpt_q[7] : snap_q[7]);
      else if (st_q == ST_RD && scl_fall)
        sda_pad.oe <= (cnt_q != `PXCD_BYTE_BITS) && ~tx_q[6];
      else if ((st_q == ST_AACK || st_q == ST_WACK) && scl_fall)
        sda_pad.oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port outputs
  logic [7:0] out_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= `PXCD_OUT_RST;
    end else if (strap_load) begin
      out_q <= {nib_dflt(ah_s), nib_dflt(al_s)};
    end else if (wr_apply && !brst_n_s == 1'b0) begin
      out_q <= sh_q;
    end
  end
  // Open drain: a zero bit pulls the pin low, a one releases it
  assign io_port_pins_out = 8'h00;
  assign io_port_pins_oe = ~out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Change detection
  logic [7:0] chg;
  logic smp_evt, pend_q;
  assign smp_evt = ack_evt || rd_ack;
  // Driven-low ports never count; nothing counts before the straps have settled
  assign chg = (init_q == 2'h3) ? ((in_s ^ snap_q) & out_q) : 8'h00;

  // Snapshot and flags; seeded once straps settle, so power-up shows no false change
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      snap_q <= 8'h00;
      flags_q <= 8'h00;
      rpt_q <= 8'h00;
    end else if (smp_evt || strap_load) begin
      snap_q <= in_s;
      rpt_q <= flags_q | chg;
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_q | chg;
    end
  end

  // Alert pending and read tracking; reset pin leaves both alone
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      rd_busy_q <= 1'b0;
    end else begin
      if (ack_evt)
        pend_q <= 1'b0;
      else if (|chg)
        pend_q <= 1'b1;
      if (ack_evt && rw_q)
        rd_busy_q <= 1'b1;
      else if (stop_det)
        rd_busy_q <= 1'b0;
    end
  end

  // Held released while a read runs, so a mid-read change waits for stop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      alert_n <= 1'b1;
    else
      alert_n <= ~(pend_q & ~rd_busy_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sample;
    @(posedge sys_clk) disable iff (!rstn) smp_evt |=> snap_q == $past(in_s);
  endproperty
  a_sample: assert property (p_sample) else $error("snapshot not taken");
  property p_flag_set;
    @(posedge sys_clk) disable iff (!rstn)
      (init_q == 2'h3 && !smp_evt && out_q[0] && in_s[0] != snap_q[0]) |=> flags_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_out_ignored;
    @(posedge sys_clk) disable iff (!rstn)
      (!out_q[0] && !flags_q[0] && !smp_evt && $stable(out_q)) |=> !flags_q[0];
  endproperty
  a_out_ignored: assert property (p_out_ignored) else $error("output flagged");
  property p_read_quiet;
    @(posedge sys_clk) disable iff (!rstn) rd_busy_q |=> alert_n;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("alert in read");
  property p_alert;
    @(posedge sys_clk) disable iff (!rstn) (pend_q && !rd_busy_q) |=> !alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");
  property p_nak;
    @(posedge sys_clk) disable iff (!rstn)
      (st_q == ST_ADDR && byte_end && !addr_match && brst_n_s && !stop_det && !start_det)
      |=> (st_q == ST_IDLE) ##1 !sda_pad.oe;
  endproperty
  a_nak: assert property (p_nak) else $error("foreign address handled");

  property p_write;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_apply && brst_n_s && !strap_load) |=> io_port_pins_oe == ~$past(sh_q);
  endproperty
  a_write: assert property (p_write) else $error("write not applied");

  property p_bus_reset;
    @(posedge sys_clk) disable iff (!rstn)
      !brst_n_s |=> st_q == ST_IDLE ##1 !sda_pad.oe;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("reset not idle");

  property p_start;
    @(posedge sys_clk) disable iff (!rstn)
      (start_det && brst_n_s) |=> st_q == ST_ADDR && ah_q == $past(ah_s);
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  c_read: cover property (@(posedge sys_clk) disable iff (!rstn) rd_ack);
  c_write: cover property (@(posedge sys_clk) disable iff (!rstn) wr_apply);
  c_nak: cover property (@(posedge sys_clk) disable iff (!rstn)
    st_q == ST_ADDR && byte_end && !addr_match);
  c_alert: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(alert_n));
endmodule
`default_nettype wire

// File: tb/pxcd_master.sv
// Bus master model that drives the link clock and pulls the data line low
`timescale 1ns/1ns
`default_nettype none
module pxcd_master (
  input wire logic clk,
  input wire logic sda_wire,
  input wire logic slow,
  output var logic scl,
  output var logic sda_low
);
  // Idle bus: both lines released; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Let n system edges pass, then move just after the last one
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Start, also repeated: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(4);
  endtask
  // Data moves only while the clock is low and holds through the high phase
  // Slow mode stretches the low phase; the line is read late in the high phase
  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    wt(slow ? 8 : 4);
    scl = 1'b1;
    wt(4);
    r = sda_wire;
    scl = 1'b0;
  endtask
  // Byte MSB first, then the ninth pulse clocked by the master
  // When reading, ack_in low acknowledges and high ends the read
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the port expander with change detection
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pxcd_pkg::*;
  logic sys_clk, rstn, bus_reset_n, scl, sda_low, slow, alert_n, ack;
  logic [1:0] sel_hi, sel_lo;
  logic [7:0] ext_in, pins_in, pins_out, pins_oe, q;
  pxcd_pad_s pad;
  pxcd_link_s link;
  wire logic sda_w;
  int bad_count, n_checks;
  //////////////////////////////////////////////////////////////////////////////
  // Open drain: pullups win unless someone pulls low; a driven port reads low
  assign sda_w = ~(pad.oe | sda_low);
  assign link = {scl, sda_w};
  assign pins_in = ext_in & ~pins_oe;
  // 20 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  pxcd_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .link_in(link), .sda_pad(pad),
    .bus_reset_n(bus_reset_n), .addr_select_high(sel_hi), .addr_select_low(sel_lo),
    .io_port_pins_in(pins_in), .io_port_pins_out(pins_out), .io_port_pins_oe(pins_oe),
    .alert_n(alert_n));
  pxcd_master i_mst (.clk(sys_clk), .sda_wire(sda_w), .slow(slow), .scl(scl),
    .sda_low(sda_low));
  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait for an alert level; running out ends the run
  task automatic wait_alert(input logic v);
    for (int k = 0; k < 20 && alert_n !== v; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({7'h00, alert_n}, {7'h00, v});
    if (alert_n !== v) end_of_test();
  endtask
  // Own address from the fixed top bits and both select codes
  function automatic logic [7:0] adr(input logic rd);
    return {3'h6, sel_hi, sel_lo, rd};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Straps: upper select on ground, lower on supply; only the upper nibble drives
  task automatic t_powerup();
    chk(pins_oe, 8'hf0);
    chk(pins_out, 8'h00);
    chk({7'h00, pad.out}, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
  endtask
  // Multibyte write, the second byte under a slow master
  task automatic t_write();
    i_mst.start();
    i_mst.xbyte(adr(1'b0), 1'b1, q, ack);
    chk({7'h00, ack}, 8'h00);
    i_mst.xbyte(8'h5a, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h00);
    chk(pins_oe, 8'ha5);
    slow = 1'b1;
    i_mst.xbyte(8'hff, 1'b1, q, ack);
    slow = 1'b0;
    chk(pins_oe, 8'h00);
    i_mst.stop();
  endtask
  // Selects moved to the bus-line codes: old address refused, new one taken
  task automatic t_mismatch();
    sel_hi = 2'h1;
    sel_lo = 2'h0;
    i_mst.start();
    i_mst.xbyte(8'hd6, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h01);
    i_mst.xbyte(8'h00, 1'b1, q, ack);
    chk(pins_oe, 8'h00);
    i_mst.start();
    i_mst.xbyte(adr(1'b0), 1'b1, q, ack);
    chk({7'h00, ack}, 8'h00);
    i_mst.xbyte(8'hff, 1'b1, q, ack);
    i_mst.stop();
  endtask
  // Four-byte read with port changes before and after the resample point
  task automatic t_read();
    ext_in = 8'hf7;
    wait_alert(1'b0);
    i_mst.start();
    i_mst.xbyte(adr(1'b1), 1'b1, q, ack);
    chk({7'h00, alert_n}, 8'h01);
    ext_in = 8'hd7;
    i_mst.xbyte(8'hff, 1'b0, q, ack);
    chk(q, 8'hf7);
    chk({7'h00, alert_n}, 8'h01);
    i_mst.xbyte(8'hff, 1'b0, q, ack);
    chk(q, 8'h08);
    i_mst.xbyte(8'hff, 1'b0, q, ack);
    chk(q, 8'hd7);
    ext_in = 8'h97;
    i_mst.xbyte(8'hff, 1'b1, q, ack);
    chk(q, 8'h20);
    chk({7'h00, alert_n}, 8'h01);
    i_mst.stop();
    wait_alert(1'b0);
  endtask
  // Reset pin in mid-write: engine idles, alert and ports stay as they were
  task automatic t_busreset();
    i_mst.start();
    i_mst.xbyte(adr(1'b0), 1'b1, q, ack);
    chk({7'h00, alert_n}, 8'h01);
    ext_in = 8'hff;
    wait_alert(1'b0);
    bus_reset_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    bus_reset_n = 1'b1;
    i_mst.xbyte(8'h00, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h01);
    chk(pins_oe, 8'h00);
    chk({7'h00, alert_n}, 8'h00);
    i_mst.stop();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    bus_reset_n = 1'b1;
    slow = 1'b0;
    sel_hi = 2'h2;
    sel_lo = 2'h3;
    ext_in = 8'hff;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_powerup();
    t_write();
    t_mismatch();
    t_read();
    t_busreset();
    end_of_test();
  end
endmodule
`default_nettype wire
